//--- rtl/srsc_pkg.sv
// constants for the security register, soft reset and parameter header command block
package srsc_pkg;
  // opcodes
  localparam logic [7:0] OP_WR_DIS = 8'h04;
  localparam logic [7:0] OP_STATUS = 8'h05;
  localparam logic [7:0] OP_WR_SET = 8'h06;
  localparam logic [7:0] OP_PROG = 8'h42;
  localparam logic [7:0] OP_READ = 8'h48;
  localparam logic [7:0] OP_PARAM = 8'h5a;
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  // status byte fields
  localparam int ST_PROGRESS_BIT = 0;
  localparam int ST_LATCH_BIT = 1;
  // address fields
  localparam logic [3:0] SEC_SEL_FIRST = 4'h1;
  localparam logic [3:0] SEC_SEL_LAST = 4'h3;
  localparam int SEC_OFS_W = 11;
  localparam int SEC_IDX_W = 13;
  localparam int SEC_BYTES = 6144;
  localparam int PAGE_BYTES = 256;
  localparam logic [2:0] ADDR_BYTES_3 = 3'h3;
  localparam logic [2:0] ADDR_BYTES_4 = 3'h4;
  // timing
  localparam int MCLK_MHZ = 40;
  localparam int PROG_TIME_US = 500;
  localparam int RST_TIME_US = 30;
  localparam int RST_CYC = RST_TIME_US * MCLK_MHZ;
  localparam int RST_CNT_W = 12;
  localparam int PROG_CNT_W = 24;
  // parameter header space
  localparam logic [31:0] PH_SIGNATURE = 32'h50444653;
  localparam logic [7:0] PH_MINOR = 8'h06;
  localparam logic [7:0] PH_MAJOR = 8'h01;
  localparam logic [7:0] PH_COUNT = 8'h02;
  localparam logic [7:0] PH_FILL = 8'hff;
  localparam logic [7:0] PH0_ID = 8'h00;
  localparam logic [7:0] PH0_MINOR = 8'h06;
  localparam logic [7:0] PH0_LEN = 8'h10;
  localparam logic [23:0] PH0_PTR = 24'h000030;
  // vendor id value is arbitrary
  localparam logic [7:0] PH1_ID = 8'h5e;
  localparam logic [7:0] PH1_LEN = 8'h03;
  localparam logic [23:0] PH1_PTR = 24'h000090;
  localparam logic [7:0] PH2_ID = 8'h84;
  localparam logic [7:0] PH2_LEN = 8'h02;
  localparam logic [23:0] PH2_PTR = 24'h0000c0;
  localparam logic [7:0] PH12_MINOR = 8'h00;
  localparam logic [10:0] PH_SIZE = 11'h020;
  // byte 0 of the space in the low bits, each header little endian
  localparam logic [255:0] PH_SPACE = {
    PH_FILL, PH2_PTR, PH2_LEN, PH_MAJOR, PH12_MINOR, PH2_ID,
    PH_FILL, PH1_PTR, PH1_LEN, PH_MAJOR, PH12_MINOR, PH1_ID,
    PH_FILL, PH0_PTR, PH0_LEN, PH_MAJOR, PH0_MINOR, PH0_ID,
    PH_FILL, PH_COUNT, PH_MAJOR, PH_MINOR, PH_SIGNATURE};
  // read source
  localparam logic [1:0] SRC_STATUS = 2'h0;
  localparam logic [1:0] SRC_SEC = 2'h1;
  localparam logic [1:0] SRC_PARAM = 2'h2;
  localparam int FIFO_DEPTH = 4;
endpackage

//--- rtl/srsc_fifo.sv
// small read-ahead fifo with valid/ready on both sides
`timescale 1ns/100ps
module srsc_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_flush,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [W-1:0] i_wdata,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [W-1:0] o_rdata
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_ff [0:D-1];
  logic [AW:0] wptr_ff;
  logic [AW:0] rptr_ff;
  wire do_wr = i_wvalid & o_wready;
  wire do_rd = o_rvalid & i_rready;
  wire full = (wptr_ff[AW] != rptr_ff[AW]) && (wptr_ff[AW-1:0] == rptr_ff[AW-1:0]);
  assign o_wready = ~full;
  assign o_rvalid = wptr_ff != rptr_ff;
  assign o_rdata = mem_ff[rptr_ff[AW-1:0]];

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
    end else if (i_ce) begin
      if (i_flush) begin
        wptr_ff <= '0;
        rptr_ff <= '0;
      end else begin
        if (do_wr) wptr_ff <= wptr_ff + 1'b1;
        if (do_rd) rptr_ff <= rptr_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_ce && do_wr && !i_flush) mem_ff[wptr_ff[AW-1:0]] <= i_wdata;
  end
endmodule // srsc_fifo

//--- rtl/srsc_top.sv
// serial flash command block: security registers, two-step soft reset, parameter header read
// How it works
// - program frame: 42h, address, data bytes
// - program cycle starts at chip select high
// - progress flag high during program cycle
// - write latch cleared before cycle ends
// - eight pages per register, page wrap
// - lock bit set blocks program
// - address selects register one to three
// - read: 48h, address, dummy byte
// - read data changes on falling edge
// - offset wraps 7ffh to 000h
// - read runs until chip select high
// - reset aborts, clears volatile state
// - reset needs 66h frame then 99h
// - commands rejected during reset recovery
// - 5ah returns signature and revision
// - first header fixed contents
// - vendor and address headers contents
// - last header byte reads ffh
`timescale 1ns/100ps
module srsc_top #(
  parameter int unsigned PROG_CYC = srsc_pkg::PROG_TIME_US * srsc_pkg::MCLK_MHZ
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  input wire logic i_four_byte_addr_flag,
  input wire logic [2:0] i_secure_area_lock_bits,
  output logic o_so,
  output logic o_so_oe,
  output logic o_write_latch_flag,
  output logic o_op_in_progress_flag,
  output logic o_soft_reset
);
  typedef enum logic [2:0] {S_IDLE, S_OPCODE, S_ADDR, S_DUMMY, S_DATA, S_OUT, S_CMD, S_IGNORE} srsc_state_t;

  function automatic logic sec_addr_ok(input logic [31:0] a);
    sec_addr_ok = (a[31:16] == 16'h0000) && (a[15:12] >= srsc_pkg::SEC_SEL_FIRST) &&
                  (a[15:12] <= srsc_pkg::SEC_SEL_LAST) && !a[11];
  endfunction

  function automatic logic [srsc_pkg::SEC_IDX_W-1:0] sec_index(input logic [1:0] sel, input logic [10:0] ofs);
    logic [1:0] bank;
    bank = sel - 2'h1;
    sec_index = {bank, ofs};
  endfunction

  // pin synchronisers, the third stage only feeds edge detection
  logic cs_s1_ff, cs_s2_ff, cs_q_ff;
  logic sck_s1_ff, sck_s2_ff, sck_q_ff;
  logic si_s1_ff, si_s2_ff;
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      {cs_s1_ff, cs_s2_ff, cs_q_ff} <= 3'h7;
      {sck_s1_ff, sck_s2_ff, sck_q_ff} <= 3'h0;
      {si_s1_ff, si_s2_ff} <= 2'h0;
    end else if (i_ce) begin
      {cs_s1_ff, cs_s2_ff, cs_q_ff} <= {i_cs_n, cs_s1_ff, cs_s2_ff};
      {sck_s1_ff, sck_s2_ff, sck_q_ff} <= {i_sck, sck_s1_ff, sck_s2_ff};
      {si_s1_ff, si_s2_ff} <= {i_si, si_s1_ff};
    end
  end

  wire in_frame = ~cs_s2_ff;
  wire frame_start = ~cs_s2_ff & cs_q_ff;
  wire frame_end = cs_s2_ff & ~cs_q_ff;
  wire sck_rise = in_frame & sck_s2_ff & ~sck_q_ff;
  wire sck_fall = in_frame & ~sck_s2_ff & sck_q_ff;

  srsc_state_t st_ff, nxt_st;
  logic [2:0] bit_ff;
  logic [6:0] rx_sh_ff;
  logic [7:0] opc_ff;
  logic [2:0] abytes_ff;
  logic [31:0] addr_ff;
  logic latch_ff, progress_ff, arm_ff, rst_pulse_ff;
  logic [srsc_pkg::RST_CNT_W-1:0] rst_cnt_ff;
  logic [srsc_pkg::PROG_CNT_W-1:0] prog_cnt_ff;
  logic [7:0] pbuf_ff [0:srsc_pkg::PAGE_BYTES-1];
  logic [srsc_pkg::PAGE_BYTES-1:0] pmask_ff;
  logic [7:0] pidx_ff;
  logic [4:0] page_ff;
  logic dnz_ff;
  logic [7:0] mem_ff [0:srsc_pkg::SEC_BYTES-1];

  wire byte_done = sck_rise & (bit_ff == 3'h7);
  wire [7:0] rx_byte = {rx_sh_ff, si_s2_ff};
  wire [31:0] full_addr = {addr_ff[23:0], rx_byte};
  wire [1:0] full_sel = full_addr[13:12];
  wire rst_busy = rst_cnt_ff != '0;
  wire whole_bytes = bit_ff == 3'h0;
  wire cmd_end = frame_end & (st_ff == S_CMD) & whole_bytes;
  wire sel_locked = i_secure_area_lock_bits[full_sel - 2'h1];
  wire prog_ok = sec_addr_ok(full_addr) & latch_ff & ~sel_locked;
  wire addr_last = byte_done & (st_ff == S_ADDR) & (abytes_ff == 3'h1);
  wire prog_accept = addr_last & (opc_ff == srsc_pkg::OP_PROG) & prog_ok;
  wire prog_start = frame_end & (st_ff == S_DATA) & whole_bytes & dnz_ff;
  wire prog_done = progress_ff & (prog_cnt_ff == PROG_CYC[srsc_pkg::PROG_CNT_W-1:0] - 1'b1);
  wire rst_accept = cmd_end & (opc_ff == srsc_pkg::OP_RST) & arm_ff;

  always_comb begin
    nxt_st = st_ff;
    if (frame_end) begin
      nxt_st = S_IDLE;
    end else if (frame_start) begin
      nxt_st = rst_busy ? S_IGNORE : S_OPCODE;
    end else if (byte_done) begin
      unique case (st_ff)
        S_OPCODE: begin
          unique case (rx_byte)
            srsc_pkg::OP_PROG, srsc_pkg::OP_READ, srsc_pkg::OP_PARAM: nxt_st = progress_ff ? S_IGNORE : S_ADDR;
            srsc_pkg::OP_STATUS: nxt_st = S_OUT;
            srsc_pkg::OP_WR_SET, srsc_pkg::OP_WR_DIS, srsc_pkg::OP_RST_EN, srsc_pkg::OP_RST: nxt_st = S_CMD;
            default: nxt_st = S_IGNORE;
          endcase
        end
        S_ADDR: begin
          if (abytes_ff == 3'h1) begin
            if (opc_ff == srsc_pkg::OP_PROG) nxt_st = prog_ok ? S_DATA : S_IGNORE;
            else if (opc_ff == srsc_pkg::OP_READ) nxt_st = sec_addr_ok(full_addr) ? S_DUMMY : S_IGNORE;
            else nxt_st = S_DUMMY;
          end
        end
        S_DUMMY: nxt_st = S_OUT;
        S_CMD: nxt_st = S_IGNORE;
        S_DATA, S_OUT, S_IGNORE, S_IDLE: nxt_st = st_ff;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_ff <= S_IDLE;
      bit_ff <= 3'h0;
      rx_sh_ff <= 7'h00;
    end else if (i_ce) begin
      st_ff <= nxt_st;
      if (frame_start) bit_ff <= 3'h0;
      else if (sck_rise) bit_ff <= bit_ff + 3'h1;
      if (sck_rise) rx_sh_ff <= rx_byte[6:0];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      opc_ff <= 8'h00;
      abytes_ff <= 3'h0;
      addr_ff <= 32'h0000_0000;
    end else if (i_ce) begin
      if (frame_start) begin
        addr_ff <= 32'h0000_0000;
      end else if (byte_done && st_ff == S_OPCODE) begin
        opc_ff <= rx_byte;
        abytes_ff <= (i_four_byte_addr_flag && rx_byte != srsc_pkg::OP_PARAM) ?
                     srsc_pkg::ADDR_BYTES_4 : srsc_pkg::ADDR_BYTES_3;
      end else if (byte_done && st_ff == S_ADDR) begin
        addr_ff <= full_addr;
        abytes_ff <= abytes_ff - 3'h1;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      pmask_ff <= '0;
      pidx_ff <= 8'h00;
      page_ff <= 5'h00;
      dnz_ff <= 1'b0;
    end else if (i_ce) begin
      if (prog_accept) begin
        pmask_ff <= '0;
        pidx_ff <= full_addr[7:0];
        page_ff <= {full_sel, full_addr[10:8]};
        dnz_ff <= 1'b0;
      end else if (byte_done && st_ff == S_DATA) begin
        pmask_ff[pidx_ff] <= 1'b1;
        pidx_ff <= pidx_ff + 8'h01;
        dnz_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_ce && byte_done && st_ff == S_DATA) pbuf_ff[pidx_ff] <= rx_byte;
  end

  // array is nonvolatile and only changes at the end of a program cycle
  always_ff @(posedge i_mclk) begin
    if (i_ce && prog_done && !rst_accept) begin
      for (int i = 0; i < srsc_pkg::PAGE_BYTES; i++) begin
        if (pmask_ff[i]) mem_ff[sec_index(page_ff[4:3], {page_ff[2:0], 8'(i)})] <= pbuf_ff[i];
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      progress_ff <= 1'b0;
      prog_cnt_ff <= '0;
      latch_ff <= 1'b0;
    end else if (i_ce) begin
      if (rst_accept) begin
        progress_ff <= 1'b0;
        latch_ff <= 1'b0;
      end else begin
        if (prog_start) progress_ff <= 1'b1;
        else if (prog_done) progress_ff <= 1'b0;
        if (prog_start || (cmd_end && opc_ff == srsc_pkg::OP_WR_DIS)) latch_ff <= 1'b0;
        // a set during the cycle would undo the clear before the cycle ends
        else if (cmd_end && opc_ff == srsc_pkg::OP_WR_SET && !progress_ff) latch_ff <= 1'b1;
      end
      prog_cnt_ff <= (progress_ff && !prog_done) ? prog_cnt_ff + 1'b1 : '0;
    end
  end

  // arm kept for next frame only
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      arm_ff <= 1'b0;
      rst_cnt_ff <= '0;
      rst_pulse_ff <= 1'b0;
    end else if (i_ce) begin
      if (frame_end) arm_ff <= cmd_end && opc_ff == srsc_pkg::OP_RST_EN;
      rst_pulse_ff <= rst_accept;
      if (rst_accept) rst_cnt_ff <= srsc_pkg::RST_CNT_W'(srsc_pkg::RST_CYC);
      else if (rst_busy) rst_cnt_ff <= rst_cnt_ff - 1'b1;
    end
  end

  // read-ahead: bytes are fetched into the fifo so the first one is ready before the first falling edge
  logic rd_act_ff;
  logic [1:0] rd_src_ff, rd_sel_ff;
  logic [10:0] rd_addr_ff;
  logic fifo_wready, fifo_rvalid;
  logic [7:0] fifo_rdata;
  logic [7:0] status_byte, rd_data;
  wire rd_go = (nxt_st == S_OUT) && (st_ff != S_OUT);
  wire rd_push = rd_act_ff & fifo_wready;
  wire [7:0] param_byte = (rd_addr_ff < srsc_pkg::PH_SIZE) ?
                          srsc_pkg::PH_SPACE[{rd_addr_ff[4:0], 3'h0} +: 8] : srsc_pkg::PH_FILL;

  always_comb begin
    status_byte = 8'h00;
    status_byte[srsc_pkg::ST_PROGRESS_BIT] = progress_ff;
    status_byte[srsc_pkg::ST_LATCH_BIT] = latch_ff;
  end

  assign rd_data = (rd_src_ff == srsc_pkg::SRC_STATUS) ? status_byte :
                   (rd_src_ff == srsc_pkg::SRC_PARAM) ? param_byte :
                   mem_ff[sec_index(rd_sel_ff, rd_addr_ff)];

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      rd_act_ff <= 1'b0;
      rd_src_ff <= srsc_pkg::SRC_STATUS;
      rd_sel_ff <= 2'h1;
      rd_addr_ff <= 11'h000;
    end else if (i_ce) begin
      if (frame_end) begin
        rd_act_ff <= 1'b0;
      end else if (rd_go) begin
        rd_act_ff <= 1'b1;
        rd_src_ff <= (st_ff == S_OPCODE) ? srsc_pkg::SRC_STATUS :
                     (opc_ff == srsc_pkg::OP_PARAM) ? srsc_pkg::SRC_PARAM : srsc_pkg::SRC_SEC;
        rd_sel_ff <= addr_ff[13:12];
        rd_addr_ff <= addr_ff[10:0];
      end else if (rd_push && rd_src_ff != srsc_pkg::SRC_STATUS) begin
        rd_addr_ff <= rd_addr_ff + 11'h001;
      end
    end
  end

  logic [2:0] obit_ff;
  logic [6:0] osh_ff;
  logic so_ff, oe_ff;
  wire out_fall = sck_fall & (st_ff == S_OUT);
  wire pop = out_fall & (obit_ff == 3'h0) & fifo_rvalid;

  srsc_fifo #(.W(8), .D(srsc_pkg::FIFO_DEPTH)) u_fifo (
    .i_clk(i_mclk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_flush(frame_end),
    .i_wvalid(rd_act_ff),
    .o_wready(fifo_wready),
    .i_wdata(rd_data),
    .o_rvalid(fifo_rvalid),
    .i_rready(pop),
    .o_rdata(fifo_rdata)
  );

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      obit_ff <= 3'h0;
      osh_ff <= 7'h00;
      so_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else if (i_ce) begin
      oe_ff <= (nxt_st == S_OUT);
      if (rd_go) begin
        obit_ff <= 3'h0;
      end else if (pop) begin
        {so_ff, osh_ff} <= fifo_rdata;
        obit_ff <= 3'h1;
      end else if (out_fall && obit_ff != 3'h0) begin
        {so_ff, osh_ff} <= {osh_ff, 1'b0};
        obit_ff <= obit_ff + 3'h1;
      end
    end
  end

  assign o_so = so_ff;
  assign o_so_oe = oe_ff;
  assign o_write_latch_flag = latch_ff;
  assign o_op_in_progress_flag = progress_ff;
  assign o_soft_reset = rst_pulse_ff;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn || !i_ce);

  a_start_sets_busy: assert property (prog_start |=> progress_ff && !latch_ff) else $error("program start lost");
  a_busy_min_len: assert property ($rose(progress_ff) |-> progress_ff [*8]) else $error("program cycle too short");
  a_latch_gone_busy: assert property (progress_ff |-> !latch_ff) else $error("latch set during cycle");
  a_lock_blocks: assert property (prog_start |-> !i_secure_area_lock_bits[page_ff[4:3] - 2'h1]) else $error("locked accept");
  a_addr_decode: assert property (st_ff == S_DATA |-> addr_ff[31:16] == 16'h0000 &&
    addr_ff[15:12] inside {4'h1, 4'h2, 4'h3} && !addr_ff[11])
    else $error("bad address accepted");
  a_reset_clears: assert property (rst_accept |=> !latch_ff && !progress_ff && o_soft_reset) else $error("reset left state");
  a_recovery_rejects: assert property (frame_start && rst_busy |=> st_ff == S_IGNORE) else $error("command in recovery");
  a_busy_ignores: assert property (byte_done && st_ff == S_OPCODE && progress_ff && rx_byte == srsc_pkg::OP_READ
    |=> st_ff == S_IGNORE) else $error("read taken while busy");
  a_offset_wrap: assert property (rd_push && rd_src_ff == srsc_pkg::SRC_SEC && rd_addr_ff == 11'h7ff && !frame_end
    |=> rd_addr_ff == 11'h000) else $error("offset did not wrap");
  a_fill_byte: assert property (rd_src_ff == srsc_pkg::SRC_PARAM && rd_addr_ff[2:0] == 3'h7 |-> param_byte == 8'hff)
    else $error("fill byte wrong");
  a_so_on_fall: assert property (!frame_end && $changed(o_so) |-> $past(sck_fall)) else $error("output moved off edge");
  a_quiet_idle: assert property (cs_s2_ff |=> !o_so_oe) else $error("driving outside frame");

  c_program: cover property (prog_start ##[1:1000] !progress_ff);
  c_soft_reset: cover property (rst_accept);
  c_sec_read: cover property (pop && rd_src_ff == srsc_pkg::SRC_SEC);
  c_param_read: cover property (pop && rd_src_ff == srsc_pkg::SRC_PARAM);
endmodule // srsc_top

//--- test/srsc_host.sv
// spi host model: chip select, serial clock and serial input, mode 0
`timescale 1ns/100ps
module srsc_host (
  input wire logic i_mclk,
  input wire logic i_so,
  output logic o_cs_n,
  output logic o_sck,
  output logic o_si
);
  logic [7:0] txq[$];
  logic [7:0] rxq[$];

  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_mclk);
  endtask

  // sck half period is 4 mclk, giving the 200 ns link clock
  task automatic bit_cycle(input logic b, output logic r);
    o_si <= b;
    wait_clk(3);
    @(negedge i_mclk);
    r = i_so;
    @(posedge i_mclk);
    o_sck <= 1'b1;
    wait_clk(4);
    o_sck <= 1'b0;
  endtask

  task automatic frame(input int nrx);
    logic [7:0] b;
    logic r;
    rxq.delete();
    o_cs_n <= 1'b0;
    wait_clk(4);
    foreach (txq[i]) begin
      for (int k = 7; k >= 0; k--) begin
        bit_cycle(txq[i][k], r);
      end
    end
    for (int j = 0; j < nrx; j++) begin
      for (int k = 7; k >= 0; k--) begin
        bit_cycle(~o_si, r);
        b[k] = r;
      end
      rxq.push_back(b);
    end
    wait_clk(4);
    // chip select high ends every command
    o_cs_n <= 1'b1;
    // released input no longer shows the last bit
    o_si <= ~o_si;
    wait_clk(6);
  endtask
endmodule // srsc_host

//--- test/srsc_top_tb.sv
// self-checking bench for the security register, soft reset and header command block
`timescale 1ns/100ps
`define chk(got, exp) begin num_checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module srsc_top_tb;
  localparam int unsigned PCYC = 1000;
  logic i_mclk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_ce = 1'b1;
  logic fb = 1'b0;
  logic [2:0] lock = 3'h0;
  logic cs_n, sck, si, so, so_oe, so_line, wlf, pif, srst;
  logic [7:0] mem [int];
  int bad_count = 0;
  int num_checks = 0;
  int pulses = 0;
  int oe_cnt = 0;
  int rnd;

  always #12.5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    if (srst === 1'b1) pulses++;
    if (so_oe === 1'b1) oe_cnt++;
  end
  // undriven output line: show the inverse so a stale bit cannot pass
  assign so_line = so_oe ? so : ~so;

  srsc_top #(.PROG_CYC(PCYC)) dut_u (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(i_ce), .i_cs_n(cs_n),
    .i_sck(sck), .i_si(si), .i_four_byte_addr_flag(fb), .i_secure_area_lock_bits(lock), .o_so(so),
    .o_so_oe(so_oe), .o_write_latch_flag(wlf), .o_op_in_progress_flag(pif), .o_soft_reset(srst));
  srsc_host host_u (.i_mclk(i_mclk), .i_so(so_line), .o_cs_n(cs_n), .o_sck(sck), .o_si(si));

  function automatic logic [7:0] hdr(input int i);
    logic [7:0] t[32] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h06, 8'h01, 8'h02, 8'hff,
      8'h00, 8'h06, 8'h01, 8'h10, 8'h30, 8'h00, 8'h00, 8'hff,
      srsc_pkg::PH1_ID, 8'h00, 8'h01, 8'h03, 8'h90, 8'h00, 8'h00, 8'hff,
      8'h84, 8'h00, 8'h01, 8'h02, 8'hc0, 8'h00, 8'h00, 8'hff};
    return (i < 32) ? t[i] : 8'hff;
  endfunction

  task automatic stop_test();
    if (bad_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic cmd1(input logic [7:0] op);
    host_u.txq = '{op};
    host_u.frame(0);
  endtask

  // register select in bits 15..12, bit 11 zero
  task automatic push_addr(input int r, input logic [10:0] ofs);
    logic [31:0] a;
    a = {16'h0000, r[3:0], 1'b0, ofs};
    if (fb) host_u.txq.push_back(a[31:24]);
    host_u.txq.push_back(a[23:16]);
    host_u.txq.push_back(a[15:8]);
    host_u.txq.push_back(a[7:0]);
  endtask

  task automatic prog(input int r, input logic [10:0] ofs, input int n, input logic ok);
    logic [7:0] d;
    logic [10:0] o;
    host_u.txq = '{srsc_pkg::OP_PROG};
    push_addr(r, ofs);
    o = ofs;
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      host_u.txq.push_back(d);
      if (ok) mem[r * 2048 + int'(o)] = d;
      // data wraps inside the 256-byte page
      o = {o[10:8], o[7:0] + 8'h01};
    end
    host_u.frame(0);
  endtask

  task automatic rd(input int r, input logic [10:0] ofs, input int n);
    logic [10:0] o;
    host_u.txq = '{srsc_pkg::OP_READ};
    push_addr(r, ofs);
    host_u.txq.push_back(8'h00);
    host_u.frame(n);
    o = ofs;
    for (int i = 0; i < n; i++) begin
      `chk(host_u.rxq[i], mem[r * 2048 + int'(o)])
      o = o + 11'h001;
    end
  endtask

  task automatic stat(input logic [7:0] exp);
    host_u.txq = '{srsc_pkg::OP_STATUS};
    host_u.frame(2);
    `chk(host_u.rxq[1], exp)
  endtask

  task automatic idle();
    int n;
    n = 0;
    while (pif !== 1'b0 && n < PCYC + 200) begin
      @(posedge i_mclk);
      n++;
    end
    if (n >= PCYC + 200) begin
      bad_count++;
      stop_test();
    end
  endtask

  initial begin
    logic [10:0] ofs;
    int oe0;
    int r;
    rnd = $urandom(32'hf7cef1ca);
    repeat (4) @(posedge i_mclk);
    i_rstn <= 1'b1;
    host_u.wait_clk(4);
    `chk({wlf, pif, so_oe, srst}, 4'h0)
    host_u.txq = '{srsc_pkg::OP_PARAM, 8'h00, 8'h00, 8'h00, 8'h00};
    host_u.frame(34);
    for (int i = 0; i < 34; i++) begin
      `chk(host_u.rxq[i], hdr(i))
    end
    cmd1(srsc_pkg::OP_WR_SET);
    stat(8'h02);
    cmd1(srsc_pkg::OP_WR_DIS);
    prog(1, 11'h000, 2, 1'b0);
    host_u.wait_clk(8);
    `chk(pif, 1'b0)
    r = 1 + ($urandom % 3);
    lock <= 3'($urandom) | 3'(1 << (r - 1));
    cmd1(srsc_pkg::OP_WR_SET);
    prog(r, 11'h010, 2, 1'b0);
    host_u.wait_clk(8);
    `chk(pif, 1'b0)
    lock <= 3'h0;
    for (r = 1; r <= 3; r++) begin
      // low nibble clear keeps four bytes in one page; register 2 crosses ffh on purpose
      ofs = {3'($urandom), (r == 2) ? 8'hfe : {4'($urandom), 4'h0}};
      fb <= (r == 3);
      cmd1(srsc_pkg::OP_WR_SET);
      prog(r, ofs, 4, 1'b1);
      host_u.wait_clk(8);
      `chk({pif, wlf}, 2'b10)
      stat(8'h01);
      if (r == 1) begin
        oe0 = oe_cnt;
        rd(r, ofs, 0);
        `chk(oe_cnt, oe0)
      end
      if (r == 3) begin
        // clock enable low must hold the program timer
        i_ce <= 1'b0;
        host_u.wait_clk(PCYC + 100 + int'($urandom % 100));
        i_ce <= 1'b1;
        `chk(pif, 1'b1)
      end
      idle();
      rd(r, ofs, (r == 2) ? 2 : 4);
      if (r == 2) rd(r, {ofs[10:8], 8'h00}, 2);
      fb <= 1'b0;
    end
    cmd1(srsc_pkg::OP_WR_SET);
    prog(3, 11'h7ff, 1, 1'b1);
    idle();
    cmd1(srsc_pkg::OP_WR_SET);
    prog(3, 11'h000, 1, 1'b1);
    idle();
    rd(3, 11'h7ff, 2);
    cmd1(srsc_pkg::OP_WR_SET);
    prog(2, 11'h100, 1, 1'b0);
    cmd1(srsc_pkg::OP_RST_EN);
    cmd1(srsc_pkg::OP_RST);
    host_u.wait_clk(4);
    `chk({pif, wlf, pulses}, {2'b00, 32'd1})
    cmd1(srsc_pkg::OP_WR_SET);
    host_u.wait_clk(4);
    `chk(wlf, 1'b0)
    host_u.wait_clk(1300);
    cmd1(srsc_pkg::OP_RST);
    cmd1(srsc_pkg::OP_WR_SET);
    host_u.wait_clk(4);
    `chk({wlf, pulses}, {1'b1, 32'd1})
    // host checks busy before the reset pair
    stat(8'h02);
    cmd1(srsc_pkg::OP_RST_EN);
    cmd1(srsc_pkg::OP_RST);
    host_u.wait_clk(4);
    `chk({wlf, pulses}, {1'b0, 32'd2})
    // hardware reset in the middle of a program cycle
    host_u.wait_clk(1300);
    cmd1(srsc_pkg::OP_WR_SET);
    prog(1, 11'h020, 1, 1'b0);
    `chk(pif, 1'b1)
    i_rstn <= 1'b0;
    host_u.wait_clk(2);
    i_rstn <= 1'b1;
    host_u.wait_clk(4);
    `chk({wlf, pif, so_oe}, 3'h0)
    stat(8'h00);
    stop_test();
  end
endmodule // srsc_top_tb
